// *** common/accel_regs_map.svh ***
// register offsets, field positions and reset values for the interrupt summary / identity / range slice
`ifndef ACCEL_REGS_MAP_SVH
`define ACCEL_REGS_MAP_SVH
`define OFS_SYSTEM_STATE      8'h0b
`define OFS_INT_SUMMARY       8'h0c
`define OFS_DEVICE_IDENTITY   8'h0d
`define OFS_RANGE_CONFIG      8'h0e
`define OFS_ORIENT_STATUS     8'h10
`define OFS_FALL_MOTION_SRC   8'h16
`define OFS_X_MSB             8'h01
`define OFS_Y_MSB             8'h03
`define OFS_Z_MSB             8'h05
`define BIT_SLEEP_WAKE        7
`define BIT_ORIENT            4
`define BIT_FALL_MOTION       2
`define BIT_SAMPLE_READY      0
`define RANGE_RESET           2'h0
`define IDENTITY_DEFAULT      8'h3c
`define STATE_CODE_STANDBY    2'h0
`define STATE_CODE_WAKE       2'h1
`define STATE_CODE_SLEEP      2'h2
`endif

// *** common/accel_regs_pkg.sv ***
// types shared by the accelerometer register slice
package accel_regs_pkg;
    typedef enum logic [1:0] {
        ST_STANDBY,
        ST_WAKE,
        ST_SLEEP
    } sys_state_e;
    typedef logic [7:0] byte_t;
endpackage

// *** hw/accel_int_source_id_range_regs.sv ***
// interrupt summary, identity and full-scale range registers with auto sleep/wake sequencing
`timescale 1ns/1ps
`include "accel_regs_map.svh"

// Functional notes
// - after idle beyond sleep_timeout_limit, wake goes to sleep and picks low rate.
// - an enabled wake event leaves sleep and selects the high rate.
// - bit 7 sets on sleep/wake transitions, clears on system state register read.
// - bit 4 follows rising orientation_change when the orientation interrupt is enabled.
// - bit 4 clears only by reading the orientation status register.
// - bit 2 follows rising event_active when fall/motion interrupt is enabled.
// - bit 2 clears by reading the fall/motion source register.
// - bit 0 sets on rising new-sample or overrun when data-ready interrupt enabled.
// - bit 0 clears only after X, Y and Z MSB data have all been read.
// - read-only 8-bit identity register holds a fixed factory value.
// - two-bit range field selects 2 g, 4 g, 8 g; code 3 reserved.
// - range field resets to the 2 g setting.
// - summary flags set on rising edges of their conditions only.
// - system state reads 00 standby, 01 wake, 10 sleep.
module accel_int_source_id_range_regs #(
    parameter logic [7:0] IDENTITY = `IDENTITY_DEFAULT  // arbitrary value
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // register access from the serial interface core
    input  wire logic        reg_rd,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic [7:0]       reg_rdata,
    // mode control from the core
    input  wire logic        active_mode,
    input  wire logic        sleep_enable,
    input  wire logic [7:0]  sleep_timeout_limit,
    input  wire logic        sleep_tick,
    input  wire logic        any_interrupt,
    input  wire logic        wake_event,
    // event sources and their enables
    input  wire logic        orientation_change,
    input  wire logic        orientation_int_en,
    input  wire logic        event_active,
    input  wire logic        fall_motion_int_en,
    input  wire logic        all_axis_new_sample,
    input  wire logic        all_axis_overrun,
    input  wire logic        sample_ready_int_en,
    // status towards the core
    output logic [1:0]       range_sel,
    output logic             low_rate_sel,
    output logic [1:0]       system_state,
    output logic [7:0]       int_summary
);

    accel_regs_pkg::sys_state_e state_r, state_nxt;
    logic [7:0] idle_cnt_r;
    logic       orient_d_r, fm_d_r, drdy_d_r;
    logic       sleep_wake_flag, orientation_flag, fall_motion_flag, sample_ready_flag;
    logic [2:0] axis_read_r;
    logic [1:0] range_r;
    logic [7:0] rdata_r;
    logic [1:0] state_code_r;
    logic       low_rate_r;
    logic [7:0] summary;

    wire rd_state   = reg_rd && (reg_addr == `OFS_SYSTEM_STATE);
    wire rd_orient  = reg_rd && (reg_addr == `OFS_ORIENT_STATUS);
    wire rd_fm      = reg_rd && (reg_addr == `OFS_FALL_MOTION_SRC);
    wire rd_x       = reg_rd && (reg_addr == `OFS_X_MSB);
    wire rd_y       = reg_rd && (reg_addr == `OFS_Y_MSB);
    wire rd_z       = reg_rd && (reg_addr == `OFS_Z_MSB);
    wire wr_range   = reg_wr && (reg_addr == `OFS_RANGE_CONFIG);
    wire drdy_cond  = all_axis_new_sample || all_axis_overrun;
    wire orient_set = orientation_change && !orient_d_r && orientation_int_en;
    wire fm_set     = event_active && !fm_d_r && fall_motion_int_en;
    wire drdy_set   = drdy_cond && !drdy_d_r && sample_ready_int_en;
    wire [2:0] axis_seen = axis_read_r | {rd_z, rd_y, rd_x};
    wire axes_done  = &axis_seen;
    // strict compare: an idle count equal to the limit still counts as awake
    wire idle_over  = idle_cnt_r > sleep_timeout_limit;
    wire transition = (state_nxt != state_r) && (state_r != accel_regs_pkg::ST_STANDBY)
                      && (state_nxt != accel_regs_pkg::ST_STANDBY);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            accel_regs_pkg::ST_STANDBY: begin
                if (active_mode) begin
                    state_nxt = accel_regs_pkg::ST_WAKE;
                end
            end
            accel_regs_pkg::ST_WAKE: begin
                if (!active_mode) begin
                    state_nxt = accel_regs_pkg::ST_STANDBY;
                end else if (sleep_enable && idle_over) begin
                    state_nxt = accel_regs_pkg::ST_SLEEP;
                end
            end
            accel_regs_pkg::ST_SLEEP: begin
                if (!active_mode) begin
                    state_nxt = accel_regs_pkg::ST_STANDBY;
                end else if (wake_event) begin
                    state_nxt = accel_regs_pkg::ST_WAKE;
                end
            end
            default: state_nxt = accel_regs_pkg::ST_STANDBY;
        endcase
    end

    wire [1:0] state_code_nxt = (state_nxt == accel_regs_pkg::ST_WAKE)  ? `STATE_CODE_WAKE :
                                (state_nxt == accel_regs_pkg::ST_SLEEP) ? `STATE_CODE_SLEEP :
                                                                          `STATE_CODE_STANDBY;

    always_comb begin
        summary                    = 8'h00;
        summary[`BIT_SLEEP_WAKE]   = sleep_wake_flag;
        summary[`BIT_ORIENT]       = orientation_flag;
        summary[`BIT_FALL_MOTION]  = fall_motion_flag;
        summary[`BIT_SAMPLE_READY] = sample_ready_flag;
    end

    wire [7:0] rd_mux = (reg_addr == `OFS_SYSTEM_STATE)    ? {6'h00, state_code_r} :
                        (reg_addr == `OFS_INT_SUMMARY)     ? summary :
                        (reg_addr == `OFS_DEVICE_IDENTITY) ? IDENTITY :
                        (reg_addr == `OFS_RANGE_CONFIG)    ? {6'h00, range_r} : 8'h00;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_r      <= accel_regs_pkg::ST_STANDBY;
            state_code_r <= `STATE_CODE_STANDBY;
            low_rate_r   <= 1'b0;
        end else begin
            // code and rate select load from state_nxt so they switch on the same edge as the state
            state_r      <= state_nxt;
            state_code_r <= state_code_nxt;
            low_rate_r   <= (state_nxt == accel_regs_pkg::ST_SLEEP);
        end
    end

    // idle counter restarts on any interrupt or state change
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            idle_cnt_r <= 8'h00;
        end else if (any_interrupt || state_r != accel_regs_pkg::ST_WAKE) begin
            idle_cnt_r <= 8'h00;
        end else if (sleep_tick && !idle_over) begin
            idle_cnt_r <= idle_cnt_r + 8'h01;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            orient_d_r <= 1'b0;
            fm_d_r     <= 1'b0;
            drdy_d_r   <= 1'b0;
        end else begin
            orient_d_r <= orientation_change;
            fm_d_r     <= event_active;
            drdy_d_r   <= drdy_cond;
        end
    end

    // set wins over clear on every flag
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sleep_wake_flag   <= 1'b0;
            orientation_flag  <= 1'b0;
            fall_motion_flag  <= 1'b0;
            sample_ready_flag <= 1'b0;
        end else begin
            sleep_wake_flag   <= transition || (sleep_wake_flag && !rd_state);
            orientation_flag  <= orient_set || (orientation_flag && !rd_orient);
            fall_motion_flag  <= fm_set || (fall_motion_flag && !rd_fm);
            sample_ready_flag <= drdy_set || (sample_ready_flag && !axes_done);
        end
    end

    // axis reads accumulate; a new sample restarts the tally
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            axis_read_r <= 3'h0;
        end else if (axes_done || drdy_set) begin
            axis_read_r <= 3'h0;
        end else begin
            axis_read_r <= axis_seen;
        end
    end

    // range field; code 3 stored as written, behaviour undefined
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            range_r <= `RANGE_RESET;
        end else if (wr_range) begin
            range_r <= reg_wdata[1:0];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_r <= 8'h00;
        end else if (reg_rd) begin
            rdata_r <= rd_mux;
        end
    end

    assign reg_rdata    = rdata_r;
    assign range_sel    = range_r;
    assign low_rate_sel = low_rate_r;
    assign system_state = state_code_r;
    assign int_summary  = summary;

endmodule

// *** testbench/accel_regs_asserts.sv ***
// port assertions for the register slice
`timescale 1ns/1ps
module accel_regs_chk (
    // clock, reset and register strobes
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic       reg_rd,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    // event source and status
    input wire logic       event_active,
    input wire logic       fall_motion_int_en,
    input wire logic [1:0] range_sel,
    input wire logic       low_rate_sel,
    input wire logic [1:0] system_state,
    input wire logic [7:0] int_summary
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    property p_spare; (int_summary & 8'h6a) == 8'h00; endproperty
    a_spare: assert property (p_spare) else $error("spare summary bit set");
    property p_rst; $past(rst) |-> range_sel == 2'h0 && int_summary == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("bad value after reset");
    property p_wr; reg_wr && reg_addr == 8'h0e |=> {6'h00, range_sel} == ($past(reg_wdata) & 8'h03); endproperty
    a_wr: assert property (p_wr) else $error("range field not written");
    property p_aclr; reg_rd && reg_addr == 8'h0b ##1 $stable(system_state) |-> !int_summary[7]; endproperty
    a_aclr: assert property (p_aclr) else $error("sleep flag kept after state read");
    property p_aset; $changed(system_state) && system_state != 2'h0 && $past(system_state) != 2'h0
        |-> ##[0:1] int_summary[7]; endproperty
    a_aset: assert property (p_aset) else $error("sleep flag missed transition");
    property p_fset; $rose(event_active) && fall_motion_int_en |-> ##[1:2] int_summary[2]; endproperty
    a_fset: assert property (p_fset) else $error("motion flag not set");
    property p_fclr; reg_rd && reg_addr == 8'h16 && !event_active |=> !int_summary[2]; endproperty
    a_fclr: assert property (p_fclr) else $error("motion flag not cleared");
    property p_ohold; int_summary[4] && !(reg_rd && reg_addr == 8'h10) |=> int_summary[4]; endproperty
    a_ohold: assert property (p_ohold) else $error("orientation flag lost");
    property p_dhold; int_summary[0] && !reg_rd |=> int_summary[0]; endproperty
    a_dhold: assert property (p_dhold) else $error("data flag lost");
    property p_state; $stable(system_state) |-> system_state != 2'h3 && low_rate_sel == (system_state == 2'h2);
    endproperty
    a_state: assert property (p_state) else $error("bad state or rate select");
endmodule
bind accel_int_source_id_range_regs accel_regs_chk i_chk (.mclk, .rst, .reg_rd, .reg_wr, .reg_addr, .reg_wdata,
    .event_active, .fall_motion_int_en, .range_sel, .low_rate_sel, .system_state, .int_summary);

// *** testbench/host_model.sv ***
// host side: single byte reads and writes on the register strobes
`timescale 1ns/1ps
module host_model (
    // register strobes towards the slice
    input wire logic       mclk,
    output logic           reg_rd    = 1'b0,
    output logic           reg_wr    = 1'b0,
    output logic [7:0]     reg_addr  = 8'h00,
    output logic [7:0]     reg_wdata = 8'h00,
    input wire logic [7:0] reg_rdata
);
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        // released data must not look like the last byte
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        // registered answer stands from the strobe edge on; take it one edge later
        @(posedge mclk);
        d = reg_rdata;
    endtask
endmodule

// *** testbench/tb.sv ***
// testbench: register slice under the host model
`timescale 1ns/1ps
`include "accel_regs_map.svh"
module tb;
    localparam logic [7:0] ID_CODE = 8'ha7; // arbitrary value
    logic       mclk = 1'b0, rst = 1'b1, reg_rd, reg_wr, low_rate_sel, active_mode = 1'b0, sleep_enable = 1'b0;
    logic       sleep_tick = 1'b0, any_interrupt = 1'b0, wake_event = 1'b0, orientation_change = 1'b0;
    logic       orientation_int_en = 1'b0, event_active = 1'b0, fall_motion_int_en = 1'b0;
    logic       all_axis_new_sample = 1'b0, all_axis_overrun = 1'b0, sample_ready_int_en = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, int_summary, rb, sleep_timeout_limit = 8'h03;
    logic [1:0] range_sel, system_state;
    int         fails = 0, compares = 0;
    host_model i_host (.mclk, .reg_rd, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata);
    accel_int_source_id_range_regs #(.IDENTITY(ID_CODE)) i_dut (.mclk, .rst, .reg_rd, .reg_wr, .reg_addr,
        .reg_wdata, .reg_rdata, .active_mode, .sleep_enable, .sleep_timeout_limit, .sleep_tick, .any_interrupt,
        .wake_event, .orientation_change, .orientation_int_en, .event_active, .fall_motion_int_en,
        .all_axis_new_sample, .all_axis_overrun, .sample_ready_int_en, .range_sel, .low_rate_sel,
        .system_state, .int_summary);
    initial forever #5 mclk = ~mclk;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        i_host.rd(a, rb);
        chk(rb, exp);
    endtask
    task automatic final_report;
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        rc(`OFS_RANGE_CONFIG, 8'h00);
        rc(`OFS_INT_SUMMARY, 8'h00);
        i_host.wr(`OFS_DEVICE_IDENTITY, 8'h00);
        rc(`OFS_DEVICE_IDENTITY, ID_CODE);
        // codes 0 to 2 only, code 3 has no defined effect
        for (int c = 0; c < 3; c++) begin
            i_host.wr(`OFS_RANGE_CONFIG, 8'hfc | 8'(c));
            rc(`OFS_RANGE_CONFIG, 8'(c));
            chk({6'h00, range_sel}, 8'(c));
        end
        $display("test range done");
        @(posedge mclk);
        orientation_int_en <= 1'b1;
        orientation_change <= 1'b1;
        event_active <= 1'b1;
        rc(`OFS_INT_SUMMARY, 8'h10);
        rc(`OFS_INT_SUMMARY, 8'h10);
        i_host.rd(`OFS_ORIENT_STATUS, rb);
        rc(`OFS_INT_SUMMARY, 8'h00);
        event_active <= 1'b0;
        fall_motion_int_en <= 1'b1;
        @(posedge mclk);
        event_active <= 1'b1;
        rc(`OFS_INT_SUMMARY, 8'h04);
        event_active <= 1'b0;
        i_host.rd(`OFS_FALL_MOTION_SRC, rb);
        rc(`OFS_INT_SUMMARY, 8'h00);
        sample_ready_int_en <= 1'b1;
        all_axis_new_sample <= 1'b1;
        i_host.rd(`OFS_X_MSB, rb);
        i_host.rd(`OFS_Y_MSB, rb);
        rc(`OFS_INT_SUMMARY, 8'h01);
        i_host.rd(`OFS_Z_MSB, rb);
        rc(`OFS_INT_SUMMARY, 8'h00);
        // drop the new-sample level so the overrun alone gives a rising edge
        all_axis_new_sample <= 1'b0;
        @(posedge mclk);
        all_axis_overrun <= 1'b1;
        $display("test flags done");
        active_mode <= 1'b1;
        sleep_enable <= 1'b1;
        rc(`OFS_SYSTEM_STATE, 8'h01);
        repeat (10) @(posedge mclk) sleep_tick <= ~sleep_tick;
        chk({7'h00, low_rate_sel}, 8'h01);
        chk({6'h00, system_state}, 8'h02);
        chk(int_summary, 8'h81);
        rc(`OFS_INT_SUMMARY, 8'h81);
        rc(`OFS_SYSTEM_STATE, 8'h02);
        rc(`OFS_INT_SUMMARY, 8'h01);
        wake_event <= 1'b1;
        rc(`OFS_INT_SUMMARY, 8'h81);
        rc(`OFS_SYSTEM_STATE, 8'h01);
        rc(`OFS_INT_SUMMARY, 8'h01);
        chk({7'h00, low_rate_sel}, 8'h00);
        $display("test sleep done");
        final_report;
    end
    initial begin
        repeat (5000) @(posedge mclk);
        fails++;
        final_report;
    end
endmodule
